// >>> rtl/loop_pwm_pkg.sv
// Package with constants, register map and carrier types of the loop timer PWM channel.
package loop_pwm_pkg;
    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFF    = 8'h00;
    localparam logic [7:0] PRESC_OFF   = 8'h04;
    localparam logic [7:0] LIMIT_OFF   = 8'h08;
    localparam logic [7:0] CMPW_OFF    = 8'h0C;
    localparam logic [7:0] STATUS_OFF  = 8'h10;
    // ------------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------------
    localparam int CTRL_EN_BIT      = 0;
    localparam int CTRL_PACT_BIT    = 1;
    localparam int CTRL_PULSE_BIT   = 2;
    localparam int FINE_DIV_LSB     = 0;
    localparam int LOOP_SEL_LSB     = 8;
    localparam int FINE_W           = 7;
    localparam int COARSE_W         = 25;
    localparam int DIV_W            = 6;
    localparam int LSEL_W           = 3;
    localparam int STAT_PIN_BIT     = 25;
    // ------------------------------------------------------------------
    // Reset values and response codes
    // ------------------------------------------------------------------
    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] PRESC_RST = 32'h0000_0301;
    localparam logic [31:0] LIMIT_RST = 32'h0000_0000;
    localparam logic [31:0] CMPW_RST  = 32'h0000_0000;
    localparam logic [1:0]  RESP_OK   = 2'b00;
    localparam logic [1:0]  RESP_ERR  = 2'b10;

    // Settings passed from the register file to the timing engine.
    typedef struct packed {
        logic                enable;
        logic                pin_action;
        logic                pulse_high;
        logic [DIV_W-1:0]    fine_divide_ratio;
        logic [LSEL_W-1:0]   loop_sel;
        logic [COARSE_W-1:0] counter_wrap_limit;
        logic [31:0]         compare_word_field;
    } pwm_cfg_t;
endpackage : loop_pwm_pkg

// >>> rtl/fine_delay_pin.sv
// Pin logic that places a match edge a number of fine periods into the loop period.
`timescale 1ns/1ns
module fine_delay_pin
    import loop_pwm_pkg::*;
(
    // Clock and reset
    input  wire logic              MCLK,
    input  wire logic              RST,
    // Fine tick and loop start
    input  wire logic              fine_tick,
    input  wire logic              loop_start,
    // Requests from the compare step and the counter wrap
    input  wire logic              set_req,
    input  wire logic              clr_req,
    input  wire logic [LSEL_W-1:0] loop_sel,
    input  wire logic [FINE_W-1:0] fine_delay_field,
    // Pin
    output logic                   pin_q
);
    import loop_pwm_pkg::*;

    logic              armed_q, armed_d;
    logic [FINE_W-1:0] left_q, left_d;
    logic              pin_d;
    logic [FINE_W-1:0] delay;

    // Only the top loop_sel bits count; lower bits are shifted out.
    always_comb begin
        delay = fine_delay_field >> (FINE_W - int'(loop_sel));
        if (loop_sel == '0) begin
            delay = '0;
        end
    end

    always_comb begin
        armed_d = armed_q;
        left_d  = left_q;
        pin_d   = pin_q;
        if (clr_req) begin
            pin_d   = 1'b0;
            armed_d = 1'b0;
        end else if (set_req) begin
            if (delay == '0) begin
                pin_d = 1'b1;
            end else begin
                armed_d = 1'b1;
                left_d  = delay;
            end
        end else if (armed_q && fine_tick) begin
            if (left_q == 7'h01) begin
                pin_d   = 1'b1;
                armed_d = 1'b0;
            end
            left_d = left_q - 7'h01;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            armed_q <= 1'b0;
            left_q  <= '0;
            pin_q   <= 1'b0;
        end else begin
            armed_q <= armed_d;
            left_q  <= left_d;
            pin_q   <= pin_d;
        end
    end

    property p_delay_zero_immediate;
        @(posedge MCLK) disable iff (RST)
        set_req && !clr_req && delay == '0 |=> pin_q;
    endproperty
    a_delay_zero_immediate : assert property (p_delay_zero_immediate)
        else $error("Zero fine delay did not raise the pin at once.");

    property p_clear_low;
        @(posedge MCLK) disable iff (RST)
        clr_req |=> !pin_q;
    endproperty
    a_clear_low : assert property (p_clear_low)
        else $error("Pin not low after counter wrap.");

    unused_loop_start : cover property (@(posedge MCLK) loop_start && armed_q);
endmodule : fine_delay_pin

// >>> rtl/loop_timer_pwm_channel.sv
// Loop timer PWM channel: prescalers, counter and compare steps, AXI4-Lite registers.
`timescale 1ns/1ns
// Summary of operation
// - Fine divide ratio one makes fine ticks every peripheral clock.
// - Loop period is the granularity of PWM period and bounds steps per loop.
// - A loop period holds loop-divide-ratio fine cycles.
// - Timeslots per loop equal loop ratio times fine ratio clocks.
// - Counter step adds one each loop, returns to zero after its limit.
// - PWM period is limit plus one loops, times loop ratio fine cycles.
// - Compare step drives the pin high when compare equals counter.
// - Compare word holds fine part in low 7 bits, coarse in upper 25.
// - For loop divider two to k only top k fine bits count.
// - Counter step copies its new value into the working register.
// - Pulse-high mode clears pin on counter wrap and sets it on a match at any other loop start.
// - Pin edge is delayed by the valid fine bits in fine cycles.
module loop_timer_pwm_channel
    import loop_pwm_pkg::*;
(
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST,
    // AXI4-Lite write channels
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    // AXI4-Lite read channels
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    // PWM pin
    output logic             PWM_PIN
);
    import loop_pwm_pkg::*;

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [31:0] ctrl_q, ctrl_d, presc_q, presc_d, limit_q, limit_d, cmpw_q, cmpw_d;
    logic        aw_got_q, aw_got_d, w_got_q, w_got_d, bvalid_q, bvalid_d;
    logic [7:0]  awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic        rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [COARSE_W-1:0] work_q, work_d, count_q, count_d;
    pwm_cfg_t    cfg;

    function automatic logic mapped(input logic [7:0] a);
        return a == CTRL_OFF || a == PRESC_OFF || a == LIMIT_OFF || a == CMPW_OFF
            || a == STATUS_OFF;
    endfunction : mapped

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    assign AWREADY = !aw_got_q && !bvalid_q;
    assign WREADY  = !w_got_q && !bvalid_q;
    assign ARREADY = !rvalid_q;
    assign BVALID  = bvalid_q;
    assign BRESP   = bresp_q;
    assign RVALID  = rvalid_q;
    assign RRESP   = rresp_q;
    assign RDATA   = rdata_q;

    always_comb begin
        logic        do_wr;
        logic [7:0]  wa;
        logic [31:0] wd;
        logic [3:0]  ws;
        do_wr    = 1'b0;
        aw_got_d = aw_got_q;
        w_got_d  = w_got_q;
        awaddr_d = awaddr_q;
        wdata_d  = wdata_q;
        wstrb_d  = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d  = bresp_q;
        ctrl_d   = ctrl_q;
        presc_d  = presc_q;
        limit_d  = limit_q;
        cmpw_d   = cmpw_q;
        if (AWVALID && AWREADY) begin
            aw_got_d = 1'b1;
            awaddr_d = AWADDR;
        end
        if (WVALID && WREADY) begin
            w_got_d = 1'b1;
            wdata_d = WDATA;
            wstrb_d = WSTRB;
        end
        wa = aw_got_q ? awaddr_q : AWADDR;
        wd = w_got_q ? wdata_q : WDATA;
        ws = w_got_q ? wstrb_q : WSTRB;
        if ((aw_got_q || (AWVALID && AWREADY)) && (w_got_q || (WVALID && WREADY))) begin
            do_wr    = 1'b1;
            aw_got_d = 1'b0;
            w_got_d  = 1'b0;
            bvalid_d = 1'b1;
            bresp_d  = mapped(wa) ? RESP_OK : RESP_ERR;
        end else if (bvalid_q && BREADY) begin
            bvalid_d = 1'b0;
        end
        if (do_wr) begin
            unique case (wa)
                CTRL_OFF:  ctrl_d  = merge(ctrl_q, wd, ws);
                PRESC_OFF: presc_d = merge(presc_q, wd, ws);
                LIMIT_OFF: limit_d = merge(limit_q, wd, ws);
                CMPW_OFF:  cmpw_d  = merge(cmpw_q, wd, ws);
                default:   ;
            endcase
        end
    end

    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (ARVALID && ARREADY) begin
            rvalid_d = 1'b1;
            rresp_d  = mapped(ARADDR) ? RESP_OK : RESP_ERR;
            unique case (ARADDR)
                CTRL_OFF:   rdata_d = {29'h0, ctrl_q[2:0]};
                PRESC_OFF:  rdata_d = {21'h0, presc_q[10:8], 2'h0, presc_q[5:0]};
                LIMIT_OFF:  rdata_d = {7'h0, limit_q[COARSE_W-1:0]};
                CMPW_OFF:   rdata_d = cmpw_q;
                STATUS_OFF: rdata_d = {6'h0, PWM_PIN, count_q};
                default:    rdata_d = 32'h0000_0000;
            endcase
        end else if (rvalid_q && RREADY) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            ctrl_q   <= CTRL_RST;
            presc_q  <= PRESC_RST;
            limit_q  <= LIMIT_RST;
            cmpw_q   <= CMPW_RST;
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            awaddr_q <= '0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OK;
            rvalid_q <= 1'b0;
            rresp_q  <= RESP_OK;
            rdata_q  <= '0;
        end else begin
            ctrl_q   <= ctrl_d;
            presc_q  <= presc_d;
            limit_q  <= limit_d;
            cmpw_q   <= cmpw_d;
            aw_got_q <= aw_got_d;
            w_got_q  <= w_got_d;
            awaddr_q <= awaddr_d;
            wdata_q  <= wdata_d;
            wstrb_q  <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q  <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q  <= rresp_d;
            rdata_q  <= rdata_d;
        end
    end

    assign cfg = '{enable:             ctrl_q[CTRL_EN_BIT],
                   pin_action:         ctrl_q[CTRL_PACT_BIT],
                   pulse_high:         ctrl_q[CTRL_PULSE_BIT],
                   fine_divide_ratio:  presc_q[FINE_DIV_LSB +: DIV_W],
                   loop_sel:           presc_q[LOOP_SEL_LSB +: LSEL_W],
                   counter_wrap_limit: limit_q[COARSE_W-1:0],
                   compare_word_field: cmpw_q};

    // ------------------------------------------------------------------
    // Prescalers and step engine
    // ------------------------------------------------------------------
    // A fine divide ratio of zero is treated as one so the engine never stalls.
    logic [DIV_W-1:0] fdiv_q, fdiv_d;
    logic [FINE_W-1:0] lcnt_q, lcnt_d;
    logic fine_tick, loop_start, wrap, match, set_req, clr_req;
    logic [FINE_W:0] loop_ratio;

    assign loop_ratio = 8'h01 << cfg.loop_sel;
    assign fine_tick  = cfg.enable && (fdiv_q == '0);
    assign loop_start = fine_tick && (lcnt_q == '0);

    always_comb begin
        fdiv_d = fdiv_q;
        lcnt_d = lcnt_q;
        if (!cfg.enable) begin
            fdiv_d = '0;
            lcnt_d = '0;
        end else begin
            fdiv_d = (fdiv_q + 6'h01 >= cfg.fine_divide_ratio) ? '0 : fdiv_q + 6'h01;
            if (fine_tick) begin
                lcnt_d = ({1'b0, lcnt_q} + 8'h01 >= loop_ratio) ? '0 : lcnt_q + 7'h01;
            end
        end
    end

    // Compare takes the working value as it is copied, so a match lines up with the
    // loop start, like the wrap clear, and the fine delay counts from that same clock.
    assign wrap = loop_start && (count_q == cfg.counter_wrap_limit);
    assign match = loop_start && (work_d == cfg.compare_word_field[31:FINE_W]);
    assign set_req = match && cfg.pin_action;
    assign clr_req = loop_start && wrap && cfg.pulse_high && cfg.pin_action;

    always_comb begin
        count_d = count_q;
        work_d  = work_q;
        if (!cfg.enable) begin
            count_d = '0;
            work_d  = '0;
        end else if (loop_start) begin
            count_d = wrap ? '0 : count_q + 25'h1;
            work_d  = count_d;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            fdiv_q  <= '0;
            lcnt_q  <= '0;
            count_q <= '0;
            work_q  <= '0;
        end else begin
            fdiv_q  <= fdiv_d;
            lcnt_q  <= lcnt_d;
            count_q <= count_d;
            work_q  <= work_d;
        end
    end

    fine_delay_pin u_pin (
        .MCLK             (MCLK),
        .RST              (RST),
        .fine_tick        (fine_tick),
        .loop_start       (loop_start),
        .set_req          (set_req),
        .clr_req          (clr_req),
        .loop_sel         (cfg.loop_sel),
        .fine_delay_field (cfg.compare_word_field[FINE_W-1:0]),
        .pin_q            (PWM_PIN)
    );

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_count_wraps;
        @(posedge MCLK) disable iff (RST)
        wrap && cfg.enable |=> count_q == '0;
    endproperty
    a_count_wraps : assert property (p_count_wraps)
        else $error("Counter did not return to zero after its limit.");

    property p_count_incr;
        @(posedge MCLK) disable iff (RST)
        loop_start && !wrap |=> count_q == $past(count_q) + 25'h1;
    endproperty
    a_count_incr : assert property (p_count_incr)
        else $error("Counter did not add one at loop start.");

    property p_work_copy;
        @(posedge MCLK) disable iff (RST)
        loop_start |=> work_q == count_q;
    endproperty
    a_work_copy : assert property (p_work_copy)
        else $error("Working register does not hold the new count.");

    property p_full_rate;
        @(posedge MCLK) disable iff (RST)
        cfg.enable && cfg.fine_divide_ratio == 6'h01 && $past(cfg.enable) |-> fine_tick;
    endproperty
    a_full_rate : assert property (p_full_rate)
        else $error("Fine tick missing at divide ratio one.");

    property p_loop_len8;
        @(posedge MCLK) disable iff (RST)
        loop_start && cfg.fine_divide_ratio == 6'h01 && cfg.loop_sel == 3'd3
            ##1 cfg.enable [*7] |-> !loop_start ##1 loop_start;
    endproperty
    a_loop_len8 : assert property (p_loop_len8)
        else $error("Loop period is not eight clocks at divide by eight.");

    property p_match_sets;
        @(posedge MCLK) disable iff (RST)
        set_req && !clr_req && cfg.loop_sel == '0 |=> PWM_PIN;
    endproperty
    a_match_sets : assert property (p_match_sets)
        else $error("Match did not raise the pin.");

    c_wrap  : cover property (@(posedge MCLK) wrap);
    c_match : cover property (@(posedge MCLK) set_req);
    c_rise  : cover property (@(posedge MCLK) $rose(PWM_PIN));
    c_fall  : cover property (@(posedge MCLK) $fell(PWM_PIN));
endmodule : loop_timer_pwm_channel

// >>> verification/pin_monitor.sv
// Far-side model of the PWM pin: measures low time and period between pin edges.
`timescale 1ns/1ns
module pin_monitor (
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST,
    // Observed pin and measurement request
    input  wire logic        pin,
    input  wire logic        arm,
    // One measurement, valid for one cycle
    output logic             meas_valid,
    output logic [31:0]      meas_low,
    output logic [31:0]      meas_period
);
    logic [31:0] cyc;
    logic [31:0] t_rise;
    logic [31:0] t_fall;
    logic        prev;
    logic        pin_n;
    logic        armed;
    int          rises;

    // ------------------------------------------------------------------
    // Edge time stamps
    // ------------------------------------------------------------------
    // The pin is taken at the falling edge, where it is settled, not in the launching step.
    always @(negedge MCLK) pin_n <= pin;

    // Two rises after arming are needed so that both intervals lie inside one steady frame.
    always @(posedge MCLK) begin
        meas_valid <= 1'b0;
        if (RST) begin
            cyc   <= 32'h0000_0000;
            prev  <= 1'b0;
            armed <= 1'b0;
            rises <= 0;
        end else begin
            cyc  <= cyc + 32'h0000_0001;
            prev <= pin_n;
            if (arm) begin
                armed <= 1'b1;
                rises <= 0;
            end
            if (!pin_n && prev) begin
                t_fall <= cyc;
            end
            if (pin_n && !prev) begin
                t_rise <= cyc;
                if (armed && rises >= 1) begin
                    meas_valid  <= 1'b1;
                    meas_low    <= cyc - t_fall;
                    meas_period <= cyc - t_rise;
                    armed       <= 1'b0;
                end
                rises <= rises + 1;
            end
        end
    end
endmodule : pin_monitor

// >>> verification/loop_timer_pwm_channel_tb.sv
// Self-checking bench for the loop timer PWM channel.
`timescale 1ns/1ns
`define CHECK(nm, ac) begin \
    exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : ~(ac); \
    num_checks++; \
    if (exp_v !== (ac)) begin \
        num_errors++; \
        $display("unexpected %s expected %h seen %h", nm, exp_v, ac); \
    end \
end
module loop_timer_pwm_channel_tb;
    import loop_pwm_pkg::*;
    logic        MCLK    = 1'b0;
    logic        RST     = 1'b1;
    logic [7:0]  AWADDR  = 8'h00;
    logic        AWVALID = 1'b0;
    logic        AWREADY;
    logic [31:0] WDATA   = 32'h0000_0000;
    logic [3:0]  WSTRB   = 4'h0;
    logic        WVALID  = 1'b0;
    logic        WREADY;
    logic [1:0]  BRESP;
    logic        BVALID;
    logic        BREADY  = 1'b0;
    logic [7:0]  ARADDR  = 8'h00;
    logic        ARVALID = 1'b0;
    logic        ARREADY;
    logic [31:0] RDATA;
    logic [1:0]  RRESP;
    logic        RVALID;
    logic        RREADY  = 1'b0;
    logic        PWM_PIN;
    logic        arm     = 1'b0;
    logic        meas_valid;
    logic [31:0] meas_low;
    logic [31:0] meas_period;
    logic [31:0] exp_v;
    logic [31:0] exp_q[$];
    logic [31:0] rnd;
    int          num_errors = 0;
    int          num_checks = 0;
    int          seed       = 32'ha2c3;
    // Each row: loop divider exponent, fine ratio, wrap limit, high time in fine cycles.
    // Every row gives at least the two timeslots that counter and compare need.
    int          cfg[6][4]  = '{'{3, 1, 9, 50}, '{3, 1, 9, 50}, '{0, 2, 4, 3},
                                '{7, 1, 2, 251}, '{2, 3, 5, 14}, '{1, 2, 3, 1}};

    loop_timer_pwm_channel uut (
        .MCLK(MCLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
        .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
        .RREADY(RREADY), .PWM_PIN(PWM_PIN)
    );
    pin_monitor mon (
        .MCLK(MCLK), .RST(RST), .pin(PWM_PIN), .arm(arm), .meas_valid(meas_valid),
        .meas_low(meas_low), .meas_period(meas_period)
    );

    always #2 MCLK = ~MCLK;

    // ------------------------------------------------------------------
    // Closing report
    // ------------------------------------------------------------------
    task automatic stop_test();
        if (exp_q.size() > 0) begin
            num_errors++;
        end
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------------
    // AXI4-Lite master
    // ------------------------------------------------------------------
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [3:0] s, input logic [1:0] er);
        int   n;
        logic aw_hs;
        logic w_hs;
        logic b_hs;
        exp_q.push_back({30'h0000_0000, er});
        @(posedge MCLK);
        AWADDR  <= a;
        WDATA   <= d;
        WSTRB   <= s;
        AWVALID <= 1'b1;
        WVALID  <= 1'b1;
        BREADY  <= 1'b1;
        // Handshakes are judged on values settled before the edge that completes them.
        for (n = 0; n < 200; n++) begin
            @(negedge MCLK);
            aw_hs = (AWVALID === 1'b1) && (AWREADY === 1'b1);
            w_hs  = (WVALID === 1'b1) && (WREADY === 1'b1);
            b_hs  = (BVALID === 1'b1);
            @(posedge MCLK);
            if (aw_hs) AWVALID <= 1'b0;
            if (w_hs) WVALID <= 1'b0;
            if (b_hs) break;
        end
        BREADY <= 1'b0;
        if (n == 200) begin
            num_errors++;
            stop_test();
        end
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int   n;
        logic ar_hs;
        logic r_hs;
        exp_q.push_back(ed);
        exp_q.push_back({30'h0000_0000, er});
        @(posedge MCLK);
        ARADDR  <= a;
        ARVALID <= 1'b1;
        RREADY  <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(negedge MCLK);
            ar_hs = (ARVALID === 1'b1) && (ARREADY === 1'b1);
            r_hs  = (RVALID === 1'b1);
            @(posedge MCLK);
            if (ar_hs) ARVALID <= 1'b0;
            if (r_hs) break;
        end
        RREADY <= 1'b0;
        if (n == 200) begin
            num_errors++;
            stop_test();
        end
    endtask : axi_read

    // ------------------------------------------------------------------
    // One PWM setting, measured at the pin
    // ------------------------------------------------------------------
    task automatic run_pwm(input int i);
        int          k;
        int          fd;
        int          prd;
        int          low_hr;
        int          n;
        logic [31:0] cmp;
        k      = cfg[i][0];
        fd     = cfg[i][1];
        prd    = (cfg[i][2] + 1) << k;
        low_hr = prd - cfg[i][3];
        // Random junk below the valid fine bits must not move the edge.
        cmp    = 32'((low_hr << (7 - k)) | ($random(seed) & ((1 << (7 - k)) - 1)));
        axi_write(CTRL_OFF, 32'h0000_0000, 4'hF, RESP_OK);
        axi_write(PRESC_OFF, 32'((k << LOOP_SEL_LSB) | fd), 4'hF, RESP_OK);
        axi_write(LIMIT_OFF, 32'(cfg[i][2]), 4'hF, RESP_OK);
        axi_write(CMPW_OFF, cmp, 4'hF, RESP_OK);
        axi_write(CTRL_OFF, 32'h0000_0007, 4'hF, RESP_OK);
        repeat (3 * prd * fd) @(posedge MCLK);
        exp_q.push_back(32'(low_hr * fd));
        exp_q.push_back(32'(prd * fd));
        arm <= 1'b1;
        @(posedge MCLK);
        arm <= 1'b0;
        for (n = 0; n < 4 * prd * fd + 100 && exp_q.size() > 0; n++) @(posedge MCLK);
        if (exp_q.size() > 0) begin
            num_errors++;
            stop_test();
        end
        $display("test pwm setting %0d done", i);
    endtask : run_pwm

    // ------------------------------------------------------------------
    // Result watcher
    // ------------------------------------------------------------------
    // Outputs are looked at mid-cycle, where they stand settled before the next edge.
    always @(negedge MCLK) begin
        if (RST == 1'b0) begin
            if (BVALID === 1'b1 && BREADY === 1'b1) `CHECK("bresp", {30'h0000_0000, BRESP})
            if (RVALID === 1'b1 && RREADY === 1'b1) begin
                `CHECK("rdata", RDATA)
                `CHECK("rresp", {30'h0000_0000, RRESP})
            end
            if (meas_valid === 1'b1) begin
                `CHECK("low_time", meas_low)
                `CHECK("period", meas_period)
            end
        end
    end

    initial begin
        repeat (100000) @(posedge MCLK);
        $display("run did not finish in time");
        num_errors++;
        stop_test();
    end

    initial begin
        repeat (8) @(posedge MCLK);
        RST <= 1'b0;
        axi_read(CTRL_OFF, CTRL_RST, RESP_OK);
        axi_read(PRESC_OFF, PRESC_RST, RESP_OK);
        axi_read(LIMIT_OFF, LIMIT_RST, RESP_OK);
        axi_read(CMPW_OFF, CMPW_RST, RESP_OK);
        rnd = $random(seed);
        axi_write(CMPW_OFF, rnd, 4'hF, RESP_OK);
        axi_read(CMPW_OFF, rnd, RESP_OK);
        axi_write(LIMIT_OFF, 32'h0012_3456, 4'b0001, RESP_OK);
        axi_read(LIMIT_OFF, 32'h0000_0056, RESP_OK);
        axi_write(8'h14, 32'hFFFF_FFFF, 4'hF, RESP_ERR);
        axi_read(8'h14, 32'h0000_0000, RESP_ERR);
        axi_write(STATUS_OFF, 32'hFFFF_FFFF, 4'hF, RESP_OK);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            run_pwm(i);
        end
        stop_test();
    end
endmodule : loop_timer_pwm_channel_tb
